// [qdsl_loader.sv]
// serial word loader with double-buffered channel registers and bus readback
//
// The Avalon-MM register port and the address map were decided locally.
`timescale 1ns/10ps
`default_nettype none
module qdsl_loader (
   input  wire logic                              i_core_clk,
   input  wire logic                              i_sys_rst,
   // serial link pins
   input  wire logic                              i_frame_n,
   input  wire logic                              i_sclk,
   input  wire logic                              i_din,
   input  wire logic                              i_load_outputs_n,
   input  wire logic                              i_clear_all_n,
   input  wire logic                              i_chain_enable,
   input  wire logic                              i_power_down_n,
   output logic                                   o_chain_out,
   output logic                                   o_if_buf_en,
   // channel output registers
   output logic      [qdsl_pkg::CODE_W-1:0]       o_code_a,
   output logic      [qdsl_pkg::CODE_W-1:0]       o_code_b,
   output logic      [qdsl_pkg::CODE_W-1:0]       o_code_c,
   output logic      [qdsl_pkg::CODE_W-1:0]       o_code_d,
   output logic      [qdsl_pkg::N_CHAN-1:0]       o_gain,
   output logic      [qdsl_pkg::N_CHAN-1:0]       o_ref_buf,
   output logic                                   o_outputs_live,
   // avalon-mm slave
   input  wire logic [qdsl_pkg::ADDR_W-1:0]       i_avs_address,
   input  wire logic                              i_avs_read,
   input  wire logic                              i_avs_write,
   input  wire logic [31:0]                       i_avs_writedata,
   input  wire logic [3:0]                        i_avs_byteenable,
   output logic      [31:0]                       o_avs_readdata,
   output logic                                   o_avs_waitrequest
);
   import qdsl_pkg::*;

   typedef struct packed {
      qdsl_frame_t                        frame;
      logic [WORD_W-1:0]                  shift;
      logic [CNT_W-1:0]                   cnt;
      logic                               buf_en;
      logic                               chain_out;
      logic                               sclk_prev;
      logic [N_CHAN-1:0][CODE_W-1:0]      in_code;
      logic [N_CHAN-1:0]                  in_gain;
      logic [N_CHAN-1:0]                  in_buf;
      logic [N_CHAN-1:0]                  dirty;
      logic [N_CHAN-1:0][CODE_W-1:0]      out_code;
      logic [N_CHAN-1:0]                  out_gain;
      logic [N_CHAN-1:0]                  out_buf;
      logic                               live;
      logic [1:0]                         res;
      logic                               ack;
      logic [31:0]                        rdata;
   } qdsl_state_t;

   qdsl_state_t s_q;
   qdsl_state_t s_d;

   logic [N_PINS-1:0] pins_s;
   logic              frame_n_s;
   logic              sclk_s;
   logic              din_s;
   logic              load_n_s;
   logic              clear_n_s;
   logic              chain_s;
   logic              pwr_n_s;
   logic              sclk_fall;
   logic              sclk_rise;
   logic              bus_req;

   // every pin is foreign to the core clock, so all pass two flops
   qdsl_sync #(
      .W       (N_PINS),
      .RST_VAL (PIN_IDLE)
   ) u_sync (
      .i_core_clk (i_core_clk),
      .i_sys_rst  (i_sys_rst),
      .i_async    ({i_power_down_n, i_chain_enable, i_clear_all_n, i_load_outputs_n,
                    i_din, i_sclk, i_frame_n}),
      .o_sync     (pins_s)
   );

   assign frame_n_s = pins_s[0];
   assign sclk_s    = pins_s[1];
   assign din_s     = pins_s[2];
   assign load_n_s  = pins_s[3];
   assign clear_n_s = pins_s[4];
   assign chain_s   = pins_s[5];
   assign pwr_n_s   = pins_s[6];

   // edges of the sampled serial clock
   assign sclk_fall = s_q.sclk_prev & ~sclk_s;
   assign sclk_rise = ~s_q.sclk_prev & sclk_s;
   assign bus_req   = i_avs_read | i_avs_write;

   // code mask for the selected resolution; low bits of narrow parts are ignored
   function automatic logic [CODE_W-1:0] res_mask(input logic [1:0] res);
      logic [CODE_W-1:0] m;
      m = 12'hFFF;
      if (res == RES_10) begin
         m = 12'hFFC;
      end else if (res == RES_8) begin
         m = 12'hFF0;
      end
      return m;
   endfunction

   // readback word for one channel
   function automatic logic [31:0] chan_word(input qdsl_state_t st, input logic [1:0] ch);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[CODE_W-1:0]                     = st.out_code[ch];
      w[CH_OUT_GAIN]                    = st.out_gain[ch];
      w[CH_OUT_BUFR]                    = st.out_buf[ch];
      w[CH_IN_CODE +: CODE_W]           = st.in_code[ch];
      w[CH_IN_GAIN]                     = st.in_gain[ch];
      w[CH_IN_BUFR]                     = st.in_buf[ch];
      return w;
   endfunction

   // next state of the whole block
   always_comb begin
      logic              do_commit;
      logic [WORD_W-1:0] word;
      logic [1:0]        ch;
      logic [WORD_W-1:0] shifted;
      logic [4:0]        ofs_idx;
      do_commit = 1'b0;
      word      = s_q.shift;
      ch        = 2'h0;
      shifted   = {s_q.shift[WORD_W-2:0], din_s};
      ofs_idx   = 5'h00;
      s_d       = s_q;
      s_d.sclk_prev = sclk_s;
      s_d.live      = pwr_n_s;                    // contents untouched in power down

      // frame sequencing on the sampled link
      case (s_q.frame)
         QDSL_IDLE: begin
            if (!frame_n_s) begin                 // low level enables the link
               s_d.frame  = QDSL_SHIFT;
               s_d.cnt    = '0;
               s_d.buf_en = 1'b1;                 // buffers up at frame start
            end
         end
         QDSL_SHIFT: begin
            if (frame_n_s) begin
               // early rise in standalone drops the word
               if (chain_s && s_q.cnt == WORD_BITS) begin
                  do_commit = 1'b1;               // last 16 bits form the word
                  word      = s_q.shift;
               end
               s_d.frame  = QDSL_IDLE;
               s_d.buf_en = 1'b0;                 // buffers down at frame end
            end else if (sclk_fall) begin
               s_d.shift = shifted;               // MSB first, one per falling edge
               if (s_q.cnt != WORD_BITS) begin
                  s_d.cnt = s_q.cnt + 5'h01;
               end
               if (!chain_s && s_q.cnt == WORD_BITS - 5'h01) begin
                  do_commit = 1'b1;               // word complete on 16th edge
                  word      = shifted;
                  s_d.frame = QDSL_HOLD;          // further pulses ignored
               end
            end else if (sclk_rise && chain_s && s_q.cnt == WORD_BITS) begin
               // gating removed in chain mode, surplus bit out on rise
               s_d.chain_out = s_q.shift[WORD_W-1];
            end
         end
         QDSL_HOLD: begin
            if (frame_n_s) begin                  // only a new frame reopens
               s_d.frame  = QDSL_IDLE;
               s_d.buf_en = 1'b0;
            end
         end
         default: begin
            s_d.frame  = QDSL_IDLE;
            s_d.buf_en = 1'b0;
         end
      endcase

      // transparent while strobe low, but only for channels written since
      if (!load_n_s) begin
         for (int i = 0; i < N_CHAN; i++) begin
            if (s_q.dirty[i]) begin
               s_d.out_code[i] = s_q.in_code[i];
               s_d.out_gain[i] = s_q.in_gain[i];
               s_d.out_buf[i]  = s_q.in_buf[i];
               s_d.dirty[i]    = 1'b0;
            end
         end
      end

      // commit after the copy so a new write's flag survives; output follows next cycle
      if (do_commit) begin
         ch                = {word[F_SEL_HI], word[F_SEL_LO]};    // channel select
         s_d.in_code[ch]   = word[CODE_W-1:0] & res_mask(s_q.res);
         s_d.in_gain[ch]   = word[F_GAIN];                         // range bit
         s_d.in_buf[ch]    = word[F_BUFR];                         // reference bit
         s_d.dirty[ch]     = 1'b1;
      end

      // clear acts on the core clock alone, whatever the serial clock does
      if (!clear_n_s) begin
         s_d.in_code  = '0;
         s_d.in_gain  = '0;
         s_d.in_buf   = '0;
         s_d.out_code = '0;
         s_d.out_gain = '0;
         s_d.out_buf  = '0;
         s_d.dirty    = '0;
      end

      // bus slave: one wait cycle, then the access completes
      s_d.ack = bus_req & ~s_q.ack;
      if (bus_req && !s_q.ack) begin
         s_d.rdata = 32'h0000_0000;
         ofs_idx   = i_avs_address;
         if (i_avs_address == OFS_CTRL) begin
            s_d.rdata[1:0] = s_q.res;
         end else if (i_avs_address == OFS_STATUS) begin
            s_d.rdata[ST_CNT +: CNT_W]       = s_q.cnt;
            s_d.rdata[ST_ACTIVE]             = s_q.buf_en;
            s_d.rdata[ST_HOLD]               = (s_q.frame == QDSL_HOLD);
            s_d.rdata[ST_DIRTY +: N_CHAN]    = s_q.dirty;
            s_d.rdata[ST_CHAIN]              = chain_s;
            s_d.rdata[ST_PWR]                = pwr_n_s;
            s_d.rdata[ST_LOAD]               = load_n_s;
         end else if (i_avs_address >= OFS_CHAN0 && i_avs_address <= OFS_CHAN3
                      && i_avs_address[1:0] == 2'h0) begin
            ofs_idx   = i_avs_address - OFS_CHAN0;
            s_d.rdata = chan_word(s_q, ofs_idx[3:2]);
         end
      end
      // write lands on the edge where waitrequest is low; others are ignored
      if (s_q.ack && i_avs_write && i_avs_address == OFS_CTRL && i_avs_byteenable[0]) begin
         s_d.res = i_avs_writedata[1:0];
         if (i_avs_writedata[1:0] == 2'h3) begin
            s_d.res = RES_8;                      // unused code folds to narrowest part
         end
      end

      // power-on state: zeros, unbuffered, single range
      if (i_sys_rst) begin
         s_d           = '0;
         s_d.frame     = QDSL_IDLE;
         s_d.res       = RES_RST;
         s_d.sclk_prev = 1'b0;
         s_d.live      = 1'b0;
      end
   end

   // single state register
   always_ff @(posedge i_core_clk) begin
      s_q <= s_d;
   end

   // outputs straight from the state flops, except waitrequest, which also decodes the live bus request
   assign o_chain_out       = s_q.chain_out;
   assign o_if_buf_en       = s_q.buf_en;
   assign o_code_a          = s_q.out_code[0];
   assign o_code_b          = s_q.out_code[1];
   assign o_code_c          = s_q.out_code[2];
   assign o_code_d          = s_q.out_code[3];
   assign o_gain            = s_q.out_gain;
   assign o_ref_buf         = s_q.out_buf;
   assign o_outputs_live    = s_q.live;
   assign o_avs_readdata    = s_q.rdata;
   assign o_avs_waitrequest = bus_req & ~s_q.ack;
endmodule
`default_nettype wire

// [qdsl_pkg.sv]
// constants, types and layout for the quad converter serial loader
// Function
// - 16-bit shift register takes one word per frame, MSB first, on the serial clock
// - word bits 15:14 pick channel A, B, C or D (00, 01, 10, 11)
// - word bit 13 picks output range: 0 single, 1 double reference
// - word bit 12 picks reference handling: 0 unbuffered, 1 buffered
// - twelve code bits follow; 10-bit variant drops 2 LSBs, 8-bit drops 4
// - codes are straight binary, zero to full scale
// - frame select is a low-active enable; data only accepted while low
// - after frame select falls, one bit shifts per falling clock edge, 16 pulses
// - standalone: pulses after the 16th falling edge ignored until frame ends
// - a complete frame copies the word into the addressed input register
// - frame select rising before the 16th edge aborts; inputs untouched
// - load strobe high holds outputs; low lets outputs follow inputs
// - low clear, independent of the serial clock, zeroes inputs and outputs
// - interface buffers enabled at frame start, disabled at frame end
// - chain enable high removes 16-pulse gating while frame select is low
// - chain mode: surplus bits appear on chain_out, changing on rising edges
// - load strobe updates an output only if its input was written since
// - load strobe low during a write updates output right after 16th edge
// - power-on: all registers zero, unbuffered, single range
// - power down keeps contents and still accepts writes
package qdsl_pkg;
   localparam int WORD_W    = 16;
   localparam int CODE_W    = 12;
   localparam int N_CHAN    = 4;
   localparam int CNT_W     = 5;
   localparam logic [CNT_W-1:0] WORD_BITS = 5'h10;
   // word field positions
   localparam int F_SEL_HI  = 15;
   localparam int F_SEL_LO  = 14;
   localparam int F_GAIN    = 13;
   localparam int F_BUFR    = 12;
   // resolution selection held in the control register
   localparam logic [1:0] RES_12  = 2'h0;
   localparam logic [1:0] RES_10  = 2'h1;
   localparam logic [1:0] RES_8   = 2'h2;
   localparam logic [1:0] RES_RST = RES_12;
   // register byte offsets on the bus
   localparam int ADDR_W = 5;
   localparam logic [ADDR_W-1:0] OFS_CTRL   = 5'h00;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h04;
   localparam logic [ADDR_W-1:0] OFS_CHAN0  = 5'h08;
   localparam logic [ADDR_W-1:0] OFS_CHAN3  = 5'h14;
   // channel readback layout
   localparam int CH_OUT_GAIN = 12;
   localparam int CH_OUT_BUFR = 13;
   localparam int CH_IN_CODE  = 16;
   localparam int CH_IN_GAIN  = 28;
   localparam int CH_IN_BUFR  = 29;
   // status layout
   localparam int ST_CNT    = 0;
   localparam int ST_ACTIVE = 5;
   localparam int ST_HOLD   = 6;
   localparam int ST_DIRTY  = 8;
   localparam int ST_CHAIN  = 12;
   localparam int ST_PWR    = 13;
   localparam int ST_LOAD   = 14;
   // synchroniser idle levels: frame_n, sclk, din, load_n, clear_n, chain_en, pwr_n
   localparam int N_PINS = 7;
   localparam logic [N_PINS-1:0] PIN_IDLE = 7'h59;
   typedef enum logic [2:0] {
      QDSL_IDLE  = 3'b001,
      QDSL_SHIFT = 3'b010,
      QDSL_HOLD  = 3'b100
   } qdsl_frame_t;
endpackage

// [qdsl_sync.sv]
// two-stage synchroniser for the serial pins
`timescale 1ns/10ps
`default_nettype none
module qdsl_sync #(
   parameter int                 W       = 1,
   parameter logic [W-1:0]       RST_VAL = '0
) (
   input  wire logic             i_core_clk,
   input  wire logic             i_sys_rst,
   input  wire logic [W-1:0]     i_async,
   output logic      [W-1:0]     o_sync
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   // first stage feeds only the second stage
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         meta_q <= RST_VAL;
         sync_q <= RST_VAL;
      end else begin
         meta_q <= i_async;
         sync_q <= meta_q;
      end
   end

   assign o_sync = sync_q;
endmodule
`default_nettype wire

// [qdsl_loader_sva.sv]
// assertion checker bound to the serial loader ports
`timescale 1ns/10ps
`default_nettype none
module qdsl_loader_sva (
   input wire logic                        i_core_clk,
   input wire logic                        i_sys_rst,
   input wire logic                        i_frame_n,
   input wire logic                        i_sclk,
   input wire logic                        i_load_outputs_n,
   input wire logic                        i_clear_all_n,
   input wire logic                        i_power_down_n,
   input wire logic                        i_avs_read,
   input wire logic                        i_avs_write,
   input wire logic                        o_avs_waitrequest,
   input wire logic                        o_chain_out,
   input wire logic                        o_if_buf_en,
   input wire logic                        o_outputs_live,
   input wire logic [qdsl_pkg::CODE_W-1:0] o_code_a,
   input wire logic [qdsl_pkg::CODE_W-1:0] o_code_b,
   input wire logic [qdsl_pkg::CODE_W-1:0] o_code_c,
   input wire logic [qdsl_pkg::CODE_W-1:0] o_code_d,
   input wire logic [qdsl_pkg::N_CHAN-1:0] o_gain,
   input wire logic [qdsl_pkg::N_CHAN-1:0] o_ref_buf
);
   import qdsl_pkg::*;
   // whole output bank in one vector
   logic [55:0] outs;
   assign outs = {o_code_a, o_code_b, o_code_c, o_code_d, o_gain, o_ref_buf};
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_sys_rst);
   // one wait cycle, then the request is taken
   sequence s_one_wait;
      o_avs_waitrequest ##1 !o_avs_waitrequest;
   endsequence
   // pins held long enough to pass the two-flop synchroniser
   sequence s_clr_held;
      !i_clear_all_n [*4];
   endsequence
   sequence s_latched;
      (i_load_outputs_n && i_clear_all_n) [*4];
   endsequence
   AST_BUS_ONE_WAIT: assert property ($rose(i_avs_read || i_avs_write) |-> s_one_wait)
      else $error("bus answer not after one wait cycle");
   AST_BUF_ON: assert property ($fell(i_frame_n) |-> ##[1:4] o_if_buf_en)
      else $error("interface buffers not enabled at frame start");
   AST_BUF_OFF: assert property ($rose(i_frame_n) |-> ##[1:4] !o_if_buf_en)
      else $error("interface buffers not disabled at frame end");
   AST_CLR: assert property (s_clr_held |=> outs == 56'h0)
      else $error("outputs not zero under clear");
   AST_POR: assert property ($fell(i_sys_rst) |-> outs == 56'h0 && !o_chain_out)
      else $error("outputs not zero after reset");
   AST_HOLD: assert property (s_latched |=> $stable(outs))
      else $error("outputs moved while strobe high");
   AST_CHAIN_STEADY: assert property ($stable(i_sclk) [*6] |=> $stable(o_chain_out))
      else $error("chain output moved without a serial clock edge");
   AST_LIVE: assert property ($stable(i_power_down_n) [*5] |-> o_outputs_live == i_power_down_n)
      else $error("live flag does not follow power down pin");
endmodule
bind qdsl_loader qdsl_loader_sva u_sva (.i_core_clk, .i_sys_rst, .i_frame_n, .i_sclk,
   .i_load_outputs_n, .i_clear_all_n, .i_power_down_n, .i_avs_read, .i_avs_write,
   .o_avs_waitrequest, .o_chain_out, .o_if_buf_en, .o_outputs_live, .o_code_a, .o_code_b,
   .o_code_c, .o_code_d, .o_gain, .o_ref_buf);
`default_nettype wire

// [qdsl_host.sv]
// host serial port model that frames words into the loader
`timescale 1ns/10ps
`default_nettype none
module qdsl_host (
   input  wire logic i_core_clk,
   input  wire logic i_chain_out,
   output logic      o_frame_n,
   output logic      o_sclk,
   output logic      o_din
);
   // chain output bits, sampled late in each low phase
   logic [15:0] rx_q;
   // idle: frame high, serial clock parked low
   initial begin
      o_frame_n = 1'b1;
      o_sclk = 1'b0;
      o_din = 1'b0;
      rx_q = 16'h0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge i_core_clk);
   endtask
   // n bits of w, msb first; 160 ns serial clock; n under 16 aborts
   task automatic send(input logic [31:0] w, input int n);
      o_frame_n <= 1'b0;
      tick(4);
      for (int k = 0; k < n; k++) begin
         o_sclk <= 1'b1;
         o_din <= w[31-k];
         tick(4);
         o_sclk <= 1'b0;
         tick(4);
         rx_q <= {rx_q[14:0], i_chain_out};
      end
      // released data line flips so a stale level never looks valid
      o_frame_n <= 1'b1;
      o_din <= ~o_din;
      tick(8);
   endtask
endmodule
`default_nettype wire

// [tb.sv]
// self-checking bench for the serial loader
`timescale 1ns/10ps
`default_nettype none
module tb;
   import qdsl_pkg::*;
   logic i_core_clk = 1'b0, i_sys_rst = 1'b1, i_load_outputs_n = 1'b1;
   logic i_clear_all_n = 1'b1, i_chain_enable = 1'b0, i_power_down_n = 1'b1;
   logic i_avs_read = 1'b0, i_avs_write = 1'b0;
   logic [ADDR_W-1:0] i_avs_address = 5'h0;
   logic [31:0] i_avs_writedata = 32'h0, o_avs_readdata, q;
   logic [3:0] i_avs_byteenable = 4'hF;
   logic i_frame_n, i_sclk, i_din, o_chain_out, o_if_buf_en, o_outputs_live, o_avs_waitrequest;
   logic [CODE_W-1:0] o_code_a, o_code_b, o_code_c, o_code_d, codes [N_CHAN];
   logic [N_CHAN-1:0] o_gain, o_ref_buf;
   logic [15:0] w_tab [N_CHAN] = '{16'h0FFF, 16'h6000, 16'h95A5, 16'hF800};
   logic [1:0] res [3] = '{RES_12, RES_10, RES_8};
   int err_total = 0, compares = 0, cycles = 0;
   always #10 i_core_clk = ~i_core_clk;
   always_comb codes = '{o_code_a, o_code_b, o_code_c, o_code_d};
   qdsl_loader i_qdsl_loader (.i_core_clk, .i_sys_rst, .i_frame_n, .i_sclk, .i_din,
      .i_load_outputs_n, .i_clear_all_n, .i_chain_enable, .i_power_down_n, .o_chain_out,
      .o_if_buf_en, .o_code_a, .o_code_b, .o_code_c, .o_code_d, .o_gain, .o_ref_buf,
      .o_outputs_live, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
      .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest);
   qdsl_host u_host (.i_core_clk, .i_chain_out(o_chain_out), .o_frame_n(i_frame_n),
      .o_sclk(i_sclk), .o_din(i_din));
   task automatic wrap_up();
      if (err_total == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one bus transfer; held until waitrequest is seen low at a rising edge
   task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      @(posedge i_core_clk);
      i_avs_address <= a;
      i_avs_writedata <= d;
      i_avs_write <= w;
      i_avs_read <= !w;
      // sampled at the edge itself, so read data is taken where the write lands
      do @(posedge i_core_clk); while (o_avs_waitrequest !== 1'b0);
      r = o_avs_readdata;
      i_avs_write <= 1'b0;
      i_avs_read <= 1'b0;
   endtask
   // channel readback and output pins against input word wi, output word wo
   task automatic chk_ch(input int c, input logic [15:0] wi, input logic [15:0] wo);
      logic [31:0] r;
      bus(1'b0, OFS_CHAN0 + 5'(4 * c), 32'h0, r);
      chk("chan reg", {2'h0, wi[12], wi[13], wi[11:0], 2'h0, wo[12], wo[13], wo[11:0]}, r);
      chk("out code", {20'h0, wo[11:0]}, {20'h0, codes[c]});
      chk("out ctl", {30'h0, wo[13:12]}, {30'h0, o_gain[c], o_ref_buf[c]});
   endtask
   // hang guard, well above the expected run of under two thousand cycles
   always @(posedge i_core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 10000) begin
         err_total++;
         wrap_up();
      end
   end
   initial begin
      repeat (5) @(posedge i_core_clk);
      i_sys_rst <= 1'b0;
      repeat (4) @(posedge i_core_clk);
      for (int c = 0; c < N_CHAN; c++) chk_ch(c, 16'h0, 16'h0);
      bus(1'b1, 5'h18, 32'hFFFF_FFFF, q);
      bus(1'b0, 5'h18, 32'h0, q);
      chk("unmapped", 32'h0, q);
      // all four loaded with the strobe high, then one strobe updates all
      for (int c = 0; c < N_CHAN; c++) u_host.send({w_tab[c], 16'h0}, 16);
      for (int c = 0; c < N_CHAN; c++) chk_ch(c, w_tab[c], 16'h0);
      i_load_outputs_n <= 1'b0;
      repeat (6) @(posedge i_core_clk);
      i_load_outputs_n <= 1'b1;
      for (int c = 0; c < N_CHAN; c++) chk_ch(c, w_tab[c], w_tab[c]);
      u_host.send({16'h5123, 16'h0}, 10);
      chk_ch(1, w_tab[1], w_tab[1]);
      // surplus pulses, strobe low, powered down
      i_load_outputs_n <= 1'b0;
      i_power_down_n <= 1'b0;
      u_host.send({16'hA3C3, 16'hF0F0}, 20);
      chk_ch(2, 16'hA3C3, 16'hA3C3);
      chk("live", 32'h0, {31'h0, o_outputs_live});
      i_power_down_n <= 1'b1;
      for (int r = 0; r < 3; r++) begin
         bus(1'b1, OFS_CTRL, {30'h0, res[r]}, q);
         bus(1'b0, OFS_CTRL, 32'h0, q);
         chk("ctrl", {30'h0, res[r]}, q);
         u_host.send({16'h0FFF, 16'h0}, 16);
         chk_ch(0, {4'h0, 12'hFFF << (2 * r)}, {4'h0, 12'hFFF << (2 * r)});
      end
      // spare resolution code folds to the narrowest part
      bus(1'b1, OFS_CTRL, 32'h3, q);
      bus(1'b0, OFS_CTRL, 32'h0, q);
      chk("ctrl fold", {30'h0, RES_8}, q);
      // write without the low byte lane is ignored
      i_avs_byteenable <= 4'hE;
      bus(1'b1, OFS_CTRL, 32'h0, q);
      i_avs_byteenable <= 4'hF;
      bus(1'b0, OFS_CTRL, 32'h0, q);
      chk("ctrl lane", {30'h0, RES_8}, q);
      bus(1'b1, OFS_CTRL, 32'h0, q);
      // two words through the chain; the first ripples out
      i_chain_enable <= 1'b1;
      u_host.send({16'h7ABC, 16'hC123}, 32);
      chk("chain out", 32'h7ABC, {16'h0, u_host.rx_q});
      chk_ch(3, 16'hC123, 16'hC123);
      chk_ch(1, w_tab[1], w_tab[1]);
      i_chain_enable <= 1'b0;
      i_clear_all_n <= 1'b0;
      repeat (6) @(posedge i_core_clk);
      i_clear_all_n <= 1'b1;
      repeat (4) @(posedge i_core_clk);
      for (int c = 0; c < N_CHAN; c++) chk_ch(c, 16'h0, 16'h0);
      // idle status: count held at a full word, strobe still low, powered up
      bus(1'b0, OFS_STATUS, 32'h0, q);
      chk("status", (32'h1 << ST_PWR) | 32'(WORD_BITS), q);
      wrap_up();
   end
endmodule
`default_nettype wire
